// ==== hw/csa_hyst_cmp.sv ====
`timescale 1ns/10ps
module csa_hyst_cmp #(
   parameter int W = csa_pkg::CMP_W,
   parameter bit OVER = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic tick,
   input wire logic [W-1:0] value,
   input wire logic [W-1:0] thresh,
   output logic act_reg
);
   logic act_next;
   logic [W+7:0] scaled;
   logic [W+7:0] value_x;

   always_comb begin
      value_x = {8'h00, value};
      // Drop-out level is always derived from the set threshold
      if (OVER) begin
         scaled = ({8'h00, thresh} * (W+8)'(csa_pkg::RESET_LO_PCT))
            / (W+8)'(csa_pkg::PCT_FULL);
      end else begin
         scaled = ({8'h00, thresh} * (W+8)'(csa_pkg::RESET_HI_PCT))
            / (W+8)'(csa_pkg::PCT_FULL);
      end
      act_next = act_reg;
      if (tick) begin
         if (OVER) begin
            act_next = act_reg ? (value_x >= scaled) : (value > thresh);
         end else begin
            act_next = act_reg ? (value_x <= scaled) : (value < thresh);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         act_reg <= 1'b0;
      end else if (ce) begin
         act_reg <= act_next;
      end
   end
endmodule : csa_hyst_cmp

// ==== hw/csa_pkg.sv ====
package csa_pkg;
   localparam int NI = 2;
   localparam int REC_DEPTH = 12;
   localparam int MAG_W = 16;
   localparam int ANG_W = 18;
   localparam int SET_W = 14;
   localparam int DLY_W = 19;
   localparam int TMR_W = 22;
   localparam int TS_W = 32;
   localparam int SG_W = 3;
   localparam int CNT_W = 16;
   localparam int CMP_W = 32;
   localparam int IDX_W = 4;
   localparam int EV_PER = 4;
   localparam int FLT_W = 5;
   // Hysteresis percentages, relative to the threshold
   localparam int PCT_FULL = 100;
   localparam int RESET_LO_PCT = 97;
   localparam int RESET_HI_PCT = 103;
   // Ratio settings are in 0.01 % steps
   localparam int RATIO_SCALE = 10000;
   localparam int SEQ_RATIO_DEFAULT = 4900;
   localparam int DELAY_STEP_MS = 5;
   localparam int BLOCK_LEAD_MS = 5;
   // Angles in 0.01 degree
   localparam logic signed [ANG_W-1:0] ANG_FULL = 18'h08CA0;
   // Event positions within one instance
   localparam int EV_ALM_ON = 0;
   localparam int EV_ALM_OFF = 1;
   localparam int EV_BLK_ON = 2;
   localparam int EV_BLK_OFF = 3;
   // Fault code bit positions
   localparam int FLT_HIGH = 0;
   localparam int FLT_LOW = 1;
   localparam int FLT_RATIO = 2;
   localparam int FLT_SEQ = 3;
   localparam int FLT_RES = 4;
   localparam logic KIND_ALARM = 1'h0;
   localparam logic KIND_BLOCK = 1'h1;

   typedef enum logic [1:0] {
      CSA_IDLE = 2'h0,
      CSA_START = 2'h1,
      CSA_ALARM = 2'h3,
      CSA_BLOCKED = 2'h2
   } csa_state_t;

   typedef struct packed {
      logic [TS_W-1:0] stamp;
      logic kind;
      logic [2:0][MAG_W-1:0] phase;
      logic [MAG_W-1:0] residual;
      logic [MAG_W-1:0] pos_seq;
      logic [MAG_W-1:0] neg_seq;
      logic [TMR_W-1:0] remain;
      logic [FLT_W-1:0] fault;
      logic [SG_W-1:0] group;
   } csa_rec_t;
endpackage : csa_pkg

// ==== hw/csa_supervision.sv ====
`timescale 1ns/10ps
module csa_supervision #(
   parameter int DEPTH = csa_pkg::REC_DEPTH,
   parameter int CYCLE_MS = 5
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cycle_tick,
   input wire logic [2:0][csa_pkg::MAG_W-1:0] phase_mag,
   input wire logic [csa_pkg::MAG_W-1:0] pos_seq_mag,
   input wire logic [csa_pkg::MAG_W-1:0] neg_seq_mag,
   input wire logic [csa_pkg::MAG_W-1:0] isum_mag,
   input wire logic [csa_pkg::MAG_W-1:0] residual_current,
   input wire logic signed [csa_pkg::ANG_W-1:0] isum_ang,
   input wire logic signed [csa_pkg::ANG_W-1:0] residual_ang,
   input wire logic [csa_pkg::NI-1:0] block_in,
   input wire logic [csa_pkg::NI-1:0][csa_pkg::MAG_W-1:0] pickup_threshold_high,
   input wire logic [csa_pkg::NI-1:0][csa_pkg::MAG_W-1:0] pickup_threshold_low,
   input wire logic [csa_pkg::NI-1:0][csa_pkg::SET_W-1:0] phase_ratio_set,
   input wire logic [csa_pkg::NI-1:0][csa_pkg::SET_W-1:0] sequence_ratio,
   input wire logic [csa_pkg::NI-1:0][csa_pkg::MAG_W-1:0] residual_diff_limit,
   input wire logic [csa_pkg::NI-1:0] residual_sel,
   input wire logic [csa_pkg::NI-1:0][csa_pkg::DLY_W-1:0] definite_time_delay,
   input wire logic [csa_pkg::SG_W-1:0] setting_group,
   input wire logic [csa_pkg::TS_W-1:0] time_ms,
   input wire logic [csa_pkg::NI*csa_pkg::EV_PER-1:0] event_store_sel,
   input wire logic [csa_pkg::NI-1:0] count_clr,
   input wire logic rec_inst,
   input wire logic [csa_pkg::IDX_W-1:0] rec_idx,
   output logic [csa_pkg::NI-1:0] start_reg,
   output logic [csa_pkg::NI-1:0] blocked_reg,
   output logic [csa_pkg::NI-1:0] alarm_reg,
   output logic [csa_pkg::NI*csa_pkg::EV_PER-1:0] event_pulse_reg,
   output logic [csa_pkg::TS_W-1:0] event_time_reg,
   output logic [csa_pkg::NI-1:0][csa_pkg::CNT_W-1:0] event_count_reg,
   output logic [csa_pkg::MAG_W-1:0] diff_mag_reg,
   output logic signed [csa_pkg::ANG_W-1:0] diff_ang_reg,
   output logic rec_valid_reg,
   output csa_pkg::csa_rec_t rec_data_reg
);
   localparam int NI = csa_pkg::NI;
   localparam int EVN = NI * csa_pkg::EV_PER;
   localparam int TW = csa_pkg::TMR_W;
   localparam int CW = csa_pkg::CMP_W;
   localparam int PW = $clog2(DEPTH);

   // Front stage: blocking sample, tick delay, residual difference
   logic [NI-1:0] blk_smp_reg;
   logic [NI-1:0] blk_smp_next;
   logic step_reg;
   logic [csa_pkg::MAG_W-1:0] diff_mag_next;
   logic signed [csa_pkg::ANG_W-1:0] diff_ang_next;
   logic signed [csa_pkg::ANG_W-1:0] ang_raw;
   logic [csa_pkg::MAG_W-1:0] ph_max;
   logic [csa_pkg::MAG_W-1:0] ph_min;

   always_comb begin
      ph_max = phase_mag[0];
      ph_min = phase_mag[0];
      for (int p = 1; p < 3; p++) begin
         if (phase_mag[p] > ph_max) begin
            ph_max = phase_mag[p];
         end
         if (phase_mag[p] < ph_min) begin
            ph_min = phase_mag[p];
         end
      end
      // Held for the whole program cycle once taken
      blk_smp_next = cycle_tick ? block_in : blk_smp_reg;
      diff_mag_next = (isum_mag >= residual_current) ? isum_mag - residual_current
         : residual_current - isum_mag;
      ang_raw = isum_ang - residual_ang;
      diff_ang_next = ang_raw;
      if (ang_raw > csa_pkg::ANG_FULL) begin
         diff_ang_next = ang_raw - csa_pkg::ANG_FULL;
      end else if (ang_raw < -csa_pkg::ANG_FULL) begin
         diff_ang_next = ang_raw + csa_pkg::ANG_FULL;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         blk_smp_reg <= '0;
         step_reg <= 1'b0;
         diff_mag_reg <= '0;
         diff_ang_reg <= '0;
      end else if (ce) begin
         blk_smp_reg <= blk_smp_next;
         step_reg <= cycle_tick;
         diff_mag_reg <= diff_mag_next;
         diff_ang_reg <= diff_ang_next;
      end
   end

   // Condition comparators, evaluated on the tick; decisions follow one cycle later
   logic [NI-1:0] over_hi;
   logic [NI-1:0] all_low;
   logic [NI-1:0] ratio_ok;
   logic [NI-1:0] seq_ok;
   logic [NI-1:0] res_ok;
   logic [NI-1:0] cond_all;
   logic [CW-1:0] min_scaled;
   logic [CW-1:0] neg_scaled;

   assign min_scaled = CW'(ph_min) * CW'(csa_pkg::RATIO_SCALE);
   assign neg_scaled = CW'(neg_seq_mag) * CW'(csa_pkg::RATIO_SCALE);

   for (genvar g = 0; g < NI; g++) begin : g_inst
      csa_hyst_cmp #(.W(CW), .OVER(1'b1)) u_high (
         .sys_clk(sys_clk), .rst(rst), .ce(ce), .tick(cycle_tick),
         .value(CW'(ph_max)), .thresh(CW'(pickup_threshold_high[g])),
         .act_reg(over_hi[g]));
      csa_hyst_cmp #(.W(CW), .OVER(1'b0)) u_low (
         .sys_clk(sys_clk), .rst(rst), .ce(ce), .tick(cycle_tick),
         .value(CW'(ph_max)), .thresh(CW'(pickup_threshold_low[g])),
         .act_reg(all_low[g]));
      // Minimum over maximum below the ratio setting, without a divider
      csa_hyst_cmp #(.W(CW), .OVER(1'b0)) u_ratio (
         .sys_clk(sys_clk), .rst(rst), .ce(ce), .tick(cycle_tick),
         .value(min_scaled), .thresh(CW'(phase_ratio_set[g]) * CW'(ph_max)),
         .act_reg(ratio_ok[g]));
      csa_hyst_cmp #(.W(CW), .OVER(1'b1)) u_seq (
         .sys_clk(sys_clk), .rst(rst), .ce(ce), .tick(cycle_tick),
         .value(neg_scaled), .thresh(CW'(sequence_ratio[g]) * CW'(pos_seq_mag)),
         .act_reg(seq_ok[g]));
      csa_hyst_cmp #(.W(CW), .OVER(1'b1)) u_res (
         .sys_clk(sys_clk), .rst(rst), .ce(ce), .tick(cycle_tick),
         .value(CW'(diff_mag_reg)), .thresh(CW'(residual_diff_limit[g])),
         .act_reg(res_ok[g]));
      assign cond_all[g] = !over_hi[g]
         && !all_low[g]
         && ratio_ok[g] && seq_ok[g]
         && (!residual_sel[g] || res_ok[g]);
   end

   // Definite-time state machines, one per instance
   csa_pkg::csa_state_t st_reg [NI];
   csa_pkg::csa_state_t st_next [NI];
   logic [TW-1:0] tmr_reg [NI];
   logic [TW-1:0] tmr_next [NI];
   logic [TW-1:0] dly_ticks [NI];
   logic [TW-1:0] remain [NI];
   logic [NI-1:0] start_next;
   logic [NI-1:0] blocked_next;
   logic [NI-1:0] alarm_next;
   logic [EVN-1:0] ev_raw;
   logic [EVN-1:0] event_pulse_next;
   logic [csa_pkg::TS_W-1:0] event_time_next;
   logic [NI-1:0][csa_pkg::CNT_W-1:0] event_count_next;

   always_comb begin
      ev_raw = '0;
      for (int i = 0; i < NI; i++) begin
         dly_ticks[i] = (TW'(definite_time_delay[i]) * TW'(csa_pkg::DELAY_STEP_MS))
            / TW'(CYCLE_MS);
         remain[i] = (tmr_reg[i] < dly_ticks[i]) ? dly_ticks[i] - tmr_reg[i] : '0;
         st_next[i] = st_reg[i];
         tmr_next[i] = tmr_reg[i];
         if (step_reg) begin
            case (st_reg[i])
               csa_pkg::CSA_IDLE: begin
                  if (cond_all[i] && blk_smp_reg[i]) begin
                     st_next[i] = csa_pkg::CSA_BLOCKED;
                  end else if (cond_all[i]) begin
                     tmr_next[i] = '0;
                     st_next[i] = (dly_ticks[i] == '0) ? csa_pkg::CSA_ALARM
                        : csa_pkg::CSA_START;
                  end
               end
               csa_pkg::CSA_START: begin
                  tmr_next[i] = '0;
                  if (!cond_all[i]) begin
                     st_next[i] = csa_pkg::CSA_IDLE;
                  end else if (blk_smp_reg[i]) begin
                     st_next[i] = csa_pkg::CSA_BLOCKED;
                  end else begin
                     // Only a fixed delay: no curve, no accumulated memory
                     tmr_next[i] = tmr_reg[i] + TW'(1);
                     if (tmr_reg[i] + TW'(1) >= dly_ticks[i]) begin
                        st_next[i] = csa_pkg::CSA_ALARM;
                     end
                  end
               end
               csa_pkg::CSA_ALARM: begin
                  tmr_next[i] = '0;
                  if (!cond_all[i]) begin
                     st_next[i] = csa_pkg::CSA_IDLE;
                  end else if (blk_smp_reg[i]) begin
                     st_next[i] = csa_pkg::CSA_BLOCKED;
                  end
               end
               csa_pkg::CSA_BLOCKED: begin
                  tmr_next[i] = '0;
                  if (!cond_all[i]) begin
                     st_next[i] = csa_pkg::CSA_IDLE;
                  end else if (!blk_smp_reg[i]) begin
                     st_next[i] = (dly_ticks[i] == '0) ? csa_pkg::CSA_ALARM
                        : csa_pkg::CSA_START;
                  end
               end
               default: begin
                  st_next[i] = csa_pkg::CSA_IDLE;
                  tmr_next[i] = '0;
               end
            endcase
         end
         start_next[i] = (st_next[i] == csa_pkg::CSA_START)
            || (st_next[i] == csa_pkg::CSA_ALARM);
         blocked_next[i] = (st_next[i] == csa_pkg::CSA_BLOCKED);
         alarm_next[i] = (st_next[i] == csa_pkg::CSA_ALARM);
         ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_ALM_ON] = alarm_next[i] && !alarm_reg[i];
         ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_ALM_OFF] = !alarm_next[i] && alarm_reg[i];
         ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_BLK_ON] = blocked_next[i] && !blocked_reg[i];
         ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_BLK_OFF] = !blocked_next[i] && blocked_reg[i];
         // Increment after clear, so a coincident event is not lost
         event_count_next[i] = count_clr[i] ? '0 : event_count_reg[i];
         if (ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_ALM_ON]
            || ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_BLK_ON]) begin
            event_count_next[i] = event_count_next[i] + csa_pkg::CNT_W'(1);
         end
      end
      event_pulse_next = ev_raw & event_store_sel;
      event_time_next = (|ev_raw) ? time_ms : event_time_reg;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NI; i++) begin
            st_reg[i] <= csa_pkg::CSA_IDLE;
            tmr_reg[i] <= '0;
         end
         start_reg <= '0;
         blocked_reg <= '0;
         alarm_reg <= '0;
         event_pulse_reg <= '0;
         event_time_reg <= '0;
         event_count_reg <= '0;
      end else if (ce) begin
         for (int i = 0; i < NI; i++) begin
            st_reg[i] <= st_next[i];
            tmr_reg[i] <= tmr_next[i];
         end
         start_reg <= start_next;
         blocked_reg <= blocked_next;
         alarm_reg <= alarm_next;
         event_pulse_reg <= event_pulse_next;
         event_time_reg <= event_time_next;
         event_count_reg <= event_count_next;
      end
   end

   // Record logs: ring per instance, newest at index 0 on readout
   csa_pkg::csa_rec_t rec_mem [NI][DEPTH];
   csa_pkg::csa_rec_t rec_new [NI];
   logic [NI-1:0] rec_wr;
   logic [PW-1:0] wptr_reg [NI];
   logic [PW-1:0] wptr_next [NI];
   logic [PW:0] fill_reg [NI];
   logic [PW:0] fill_next [NI];
   logic [PW:0] rd_sum;
   logic [PW-1:0] rd_addr;
   logic rec_valid_next;

   always_comb begin
      for (int i = 0; i < NI; i++) begin
         rec_wr[i] = ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_ALM_ON]
            || ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_BLK_ON];
         rec_new[i].stamp = time_ms;
         rec_new[i].kind = ev_raw[i*csa_pkg::EV_PER+csa_pkg::EV_BLK_ON]
            ? csa_pkg::KIND_BLOCK : csa_pkg::KIND_ALARM;
         rec_new[i].phase = phase_mag;
         rec_new[i].residual = residual_current;
         rec_new[i].pos_seq = pos_seq_mag;
         rec_new[i].neg_seq = neg_seq_mag;
         rec_new[i].remain = rec_new[i].kind ? remain[i] : '0;
         rec_new[i].fault = '0;
         rec_new[i].fault[csa_pkg::FLT_HIGH] = over_hi[i];
         rec_new[i].fault[csa_pkg::FLT_LOW] = all_low[i];
         rec_new[i].fault[csa_pkg::FLT_RATIO] = ratio_ok[i];
         rec_new[i].fault[csa_pkg::FLT_SEQ] = seq_ok[i];
         rec_new[i].fault[csa_pkg::FLT_RES] = res_ok[i];
         rec_new[i].group = setting_group;
         wptr_next[i] = wptr_reg[i];
         fill_next[i] = fill_reg[i];
         if (rec_wr[i]) begin
            // Wrap overwrites the oldest entry once the log is full
            wptr_next[i] = (wptr_reg[i] == PW'(DEPTH - 1)) ? '0
               : wptr_reg[i] + PW'(1);
            if (fill_reg[i] != (PW+1)'(DEPTH)) begin
               fill_next[i] = fill_reg[i] + (PW+1)'(1);
            end
         end
      end
      rd_sum = (PW+1)'(wptr_reg[rec_inst]) + (PW+1)'(DEPTH - 1) - (PW+1)'(rec_idx);
      if (rd_sum >= (PW+1)'(DEPTH)) begin
         rd_sum = rd_sum - (PW+1)'(DEPTH);
      end
      rd_addr = rd_sum[PW-1:0];
      rec_valid_next = (PW+1)'(rec_idx) < fill_reg[rec_inst];
   end

   always_ff @(posedge sys_clk) begin
      if (ce) begin
         for (int i = 0; i < NI; i++) begin
            if (rec_wr[i]) begin
               rec_mem[i][wptr_reg[i]] <= rec_new[i];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NI; i++) begin
            wptr_reg[i] <= '0;
            fill_reg[i] <= '0;
         end
         rec_valid_reg <= 1'b0;
         rec_data_reg <= '0;
      end else if (ce) begin
         for (int i = 0; i < NI; i++) begin
            wptr_reg[i] <= wptr_next[i];
            fill_reg[i] <= fill_next[i];
         end
         rec_valid_reg <= rec_valid_next;
         rec_data_reg <= rec_valid_next ? rec_mem[rec_inst][rd_addr] : '0;
      end
   end
endmodule : csa_supervision

// ==== sim/csa_front_model.sv ====
`timescale 1ns/10ps
module csa_front_model #(
   parameter int TICK_CLKS = 4,
   parameter int CYCLE_MS = 5
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [2:0] fault_case,
   input wire logic [1:0] blk_req,
   output logic cycle_tick,
   output logic [2:0][csa_pkg::MAG_W-1:0] phase_mag,
   output logic [csa_pkg::MAG_W-1:0] pos_seq_mag,
   output logic [csa_pkg::MAG_W-1:0] neg_seq_mag,
   output logic [csa_pkg::MAG_W-1:0] isum_mag,
   output logic [csa_pkg::MAG_W-1:0] residual_current,
   output logic signed [csa_pkg::ANG_W-1:0] isum_ang,
   output logic signed [csa_pkg::ANG_W-1:0] residual_ang,
   output logic [1:0] block_in,
   output logic [csa_pkg::TS_W-1:0] time_ms
);
   // Rows: healthy, lost L1, overcurrent, low current, spare, residual matches
   localparam logic [15:0] L1_T [6] = '{16'h64, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   localparam logic [15:0] PH_T [6] = '{16'h64, 16'h64, 16'hC8, 16'h5, 16'h64, 16'h64};
   localparam logic [15:0] I1_T [6] = '{16'h64, 16'h43, 16'h85, 16'h3, 16'h43, 16'h43};
   localparam logic [15:0] I2_T [6] = '{16'h0, 16'h21, 16'h43, 16'h2, 16'h21, 16'h21};
   localparam logic [15:0] RS_T [6] = '{16'h1E, 16'h1E, 16'h1E, 16'h1E, 16'h1E, 16'h7D};
   logic [7:0] div_reg;
   assign phase_mag = {PH_T[fault_case], PH_T[fault_case], L1_T[fault_case]};
   assign pos_seq_mag = I1_T[fault_case];
   assign neg_seq_mag = I2_T[fault_case];
   assign isum_mag = 16'h0082;
   assign residual_current = RS_T[fault_case];
   assign isum_ang = 18'sh00064;
   assign residual_ang = -18'sh000C8;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_reg <= 8'h00;
         cycle_tick <= 1'b0;
         block_in <= 2'h0;
         time_ms <= 32'h0;
      end else begin
         cycle_tick <= (div_reg == 8'(TICK_CLKS - 1));
         div_reg <= (div_reg == 8'(TICK_CLKS - 1)) ? 8'h00 : div_reg + 8'h01;
         if (div_reg == 8'(TICK_CLKS - 1)) begin
            // Block moves only on ticks, ahead of any expiry
            block_in <= blk_req;
            time_ms <= time_ms + 32'(CYCLE_MS);
         end
      end
   end
endmodule : csa_front_model

// ==== sim/csa_supervision_monitor.sv ====
`timescale 1ns/10ps
module csa_supervision_monitor #(
   parameter int DEPTH = 12
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cycle_tick,
   input wire logic [csa_pkg::MAG_W-1:0] isum_mag,
   input wire logic [csa_pkg::MAG_W-1:0] residual_current,
   input wire logic [csa_pkg::NI*csa_pkg::EV_PER-1:0] event_store_sel,
   input wire logic [csa_pkg::NI-1:0] count_clr,
   input wire logic [csa_pkg::IDX_W-1:0] rec_idx,
   input wire logic [csa_pkg::NI-1:0] start_reg,
   input wire logic [csa_pkg::NI-1:0] blocked_reg,
   input wire logic [csa_pkg::NI-1:0] alarm_reg,
   input wire logic [csa_pkg::NI*csa_pkg::EV_PER-1:0] event_pulse_reg,
   input wire logic [csa_pkg::NI-1:0][csa_pkg::CNT_W-1:0] event_count_reg,
   input wire logic [csa_pkg::MAG_W-1:0] diff_mag_reg,
   input wire logic rec_valid_reg,
   input wire csa_pkg::csa_rec_t rec_data_reg
);
   logic [csa_pkg::MAG_W-1:0] abs_diff;
   assign abs_diff = (isum_mag >= residual_current) ? isum_mag - residual_current
      : residual_current - isum_mag;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_block_no_start: assert property ((blocked_reg & start_reg) == '0)
      else $error("start and blocked high together");
   a_alarm_with_start: assert property ((alarm_reg & ~start_reg) == '0)
      else $error("alarm without start");
   a_step_on_tick: assert property (!$stable({start_reg, blocked_reg, alarm_reg})
      |-> $past(cycle_tick, 2))
      else $error("change off a program step");
   a_alarm_on_event: assert property ($rose(alarm_reg[0]) && event_store_sel[0]
      |-> event_pulse_reg[0])
      else $error("alarm on pulse missing");
   a_block_on_event: assert property ($rose(blocked_reg[0]) && event_store_sel[2]
      |-> event_pulse_reg[2])
      else $error("block on pulse missing");
   a_event_masked: assert property ((event_pulse_reg & ~$past(event_store_sel)) == '0)
      else $error("masked event pulsed");
   a_count_alarm: assert property ($rose(alarm_reg[0]) && !$past(count_clr[0])
      |-> event_count_reg[0] == $past(event_count_reg[0]) + 16'h0001)
      else $error("alarm not counted");
   a_count_clear: assert property (count_clr[1] |=> event_count_reg[1] <= 16'h0001)
      else $error("counter not cleared");
   a_rec_beyond: assert property (rec_idx >= 4'(DEPTH) |=> !rec_valid_reg && rec_data_reg == '0)
      else $error("record beyond depth valid");
   a_diff_follows: assert property ($stable({isum_mag, residual_current}) [*3]
      |-> diff_mag_reg == abs_diff)
      else $error("difference magnitude wrong");
   c_alarm: cover property ($rose(alarm_reg[0]));
   c_blocked: cover property ($rose(blocked_reg[1]));
   c_record: cover property (rec_valid_reg);
endmodule : csa_supervision_monitor

// ==== sim/csa_supervision_tb.sv ====
`timescale 1ns/10ps
module csa_supervision_tb;
   localparam int DLY0 = 4;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [2:0] fcase = 3'h0;
   logic [1:0] blk = 2'h0;
   logic cycle_tick;
   logic [2:0][15:0] phase_mag;
   logic [15:0] pos_seq_mag, neg_seq_mag, isum_mag, residual_current, diff_mag_reg;
   logic signed [17:0] isum_ang, residual_ang, diff_ang_reg;
   logic [1:0] block_in, start_reg, blocked_reg, alarm_reg;
   logic [1:0] residual_sel = 2'h0;
   logic [1:0] count_clr = 2'h0;
   logic [31:0] time_ms, event_time_reg;
   logic [7:0] event_store_sel = 8'hFF;
   logic [7:0] event_pulse_reg;
   logic [1:0][15:0] event_count_reg;
   logic rec_inst = 1'b0;
   logic rec_valid_reg;
   logic [3:0] rec_idx = 4'h0;
   logic [2:0] setting_group = 3'h5;
   csa_pkg::csa_rec_t rec_data_reg;
   logic [31:0] stamps [13];
   int n_errors = 0;
   int num_checks = 0;
   int pcnt = 0;
   always #50 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (event_pulse_reg[6] === 1'b1) pcnt++;
   csa_front_model PART (.sys_clk, .rst, .fault_case(fcase), .blk_req(blk), .cycle_tick,
      .phase_mag, .pos_seq_mag, .neg_seq_mag, .isum_mag, .residual_current, .isum_ang,
      .residual_ang, .block_in, .time_ms);
   csa_supervision #(.DEPTH(12), .CYCLE_MS(5)) DUT (.sys_clk, .rst, .ce, .cycle_tick,
      .phase_mag, .pos_seq_mag, .neg_seq_mag, .isum_mag, .residual_current, .isum_ang,
      .residual_ang, .block_in, .pickup_threshold_high({16'h0096, 16'h0078}),
      .pickup_threshold_low({2{16'h000A}}), .phase_ratio_set({2{14'h03E8}}),
      .sequence_ratio({2{14'h1324}}), .residual_diff_limit({2{16'h000A}}), .residual_sel,
      .definite_time_delay({19'h00003, 19'h00004}), .setting_group, .time_ms, .event_store_sel,
      .count_clr, .rec_inst, .rec_idx, .start_reg, .blocked_reg, .alarm_reg, .event_pulse_reg,
      .event_time_reg, .event_count_reg, .diff_mag_reg, .diff_ang_reg, .rec_valid_reg,
      .rec_data_reg);
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   function automatic logic pick(input int s);
      logic [4:0] v;
      v = {blocked_reg[1], start_reg[1], blocked_reg[0], alarm_reg[0], start_reg[0]};
      return v[s];
   endfunction : pick
   // Bounded: a stuck output fails instead of hanging
   task automatic till(input int s, input logic v);
      repeat (200) if (pick(s) !== v) @(negedge sys_clk);
      chk("level", v, pick(s));
      @(posedge sys_clk);
      #1;
   endtask : till
   task automatic ticks(input int n);
      repeat (n) @(negedge sys_clk iff cycle_tick === 1'b1);
      @(posedge sys_clk);
      #1;
   endtask : ticks
   task automatic rd(input logic i, input logic [3:0] x);
      rec_inst = i;
      rec_idx = x;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : rd
   task automatic t_alarm();
      int k;
      logic [31:0] t0;
      blk = 2'h2;
      fcase = 3'h1;
      repeat (200) if (start_reg[0] !== 1'b1) @(negedge sys_clk);
      chk("blocked1", 1'b1, blocked_reg[1]);
      while (alarm_reg[0] !== 1'b1 && k < 20) begin
         @(negedge sys_clk);
         if (cycle_tick === 1'b1) k++;
      end
      chk("alarm_ticks", DLY0, k);
      chk("alarm_on_ev", 1'b1, event_pulse_reg[0]);
      chk("ev_time", time_ms, event_time_reg);
      chk("cnt0", 16'h0001, event_count_reg[0]);
      chk("alarm1", 1'b0, alarm_reg[1]);
      t0 = time_ms;
      @(posedge sys_clk);
      #1;
      rd(1'b0, 4'h0);
      chk("rec_valid", 1'b1, rec_valid_reg);
      chk("rec_kind", csa_pkg::KIND_ALARM, rec_data_reg.kind);
      chk("rec_stamp", t0, rec_data_reg.stamp);
      chk("rec_l1", 16'h0000, rec_data_reg.phase[0]);
      chk("rec_l2", 16'h0064, rec_data_reg.phase[1]);
      chk("rec_i2", 16'h0021, rec_data_reg.neg_seq);
      chk("rec_remain", 22'h0, rec_data_reg.remain);
      chk("rec_group", 3'h5, rec_data_reg.group);
      rd(1'b1, 4'h0);
      chk("rec1_kind", csa_pkg::KIND_BLOCK, rec_data_reg.kind);
      chk("rec1_remain", 22'h3, rec_data_reg.remain);
      fcase = 3'h0;
      repeat (200) if (alarm_reg[0] !== 1'b0) @(negedge sys_clk);
      chk("alarm_off_ev", 1'b1, event_pulse_reg[1]);
      till(0, 1'b0);
      blk = 2'h0;
      till(4, 1'b0);
   endtask : t_alarm
   task automatic t_drop();
      fcase = 3'h1;
      till(0, 1'b1);
      ticks(1);
      fcase = 3'h0;
      ticks(DLY0 + 2);
      chk("drop_alarm", 1'b0, alarm_reg[0]);
      chk("drop_start", 1'b0, start_reg[0]);
   endtask : t_drop
   task automatic t_inhibit();
      logic [2:0] cs [3] = '{3'h2, 3'h3, 3'h5};
      residual_sel = 2'h3;
      for (int i = 0; i < 3; i++) begin
         fcase = cs[i];
         ticks(DLY0 + 2);
         chk("inhibit_start", 1'b0, start_reg[0]);
      end
      chk("diff_mag", 16'h0005, diff_mag_reg);
      chk("diff_ang", 18'h0012C, diff_ang_reg);
      fcase = 3'h1;
      till(0, 1'b1);
      fcase = 3'h0;
      residual_sel = 2'h0;
      till(0, 1'b0);
   endtask : t_inhibit
   task automatic t_block();
      fcase = 3'h1;
      till(0, 1'b1);
      blk = 2'h1;
      repeat (200) if (blocked_reg[0] !== 1'b1) @(negedge sys_clk);
      chk("blk_start", 1'b0, start_reg[0]);
      chk("blk_on_ev", 1'b1, event_pulse_reg[2]);
      till(2, 1'b1);
      blk = 2'h0;
      till(0, 1'b1);
      fcase = 3'h0;
      till(0, 1'b0);
   endtask : t_block
   task automatic t_log();
      count_clr = 2'h2;
      ticks(1);
      count_clr = 2'h0;
      chk("cnt1_clr", 16'h0000, event_count_reg[1]);
      event_store_sel = 8'hBF;
      pcnt = 0;
      fcase = 3'h1;
      for (int i = 0; i < 13; i++) begin
         blk = 2'h2;
         till(4, 1'b1);
         stamps[i] = time_ms;
         blk = 2'h0;
         till(3, 1'b1);
      end
      chk("cnt1", 16'h000D, event_count_reg[1]);
      chk("masked_pulses", 32'h0, pcnt);
      rd(1'b1, 4'hB);
      chk("rec11_valid", 1'b1, rec_valid_reg);
      chk("rec11_stamp", stamps[1], rec_data_reg.stamp);
      rd(1'b1, 4'h0);
      chk("rec0_stamp", stamps[12], rec_data_reg.stamp);
      rd(1'b1, 4'hC);
      chk("rec12_valid", 1'b0, rec_valid_reg);
      event_store_sel = 8'hFF;
      fcase = 3'h0;
   endtask : t_log
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (16) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      t_alarm();
      t_drop();
      t_inhibit();
      t_block();
      t_log();
      wrap_up();
   end
   // Tests take some 300 clocks; wide margin
   initial begin
      #2000000;
      n_errors++;
      wrap_up();
   end
endmodule : csa_supervision_tb
bind csa_supervision csa_supervision_monitor #(.DEPTH(DEPTH)) u_mon (.sys_clk, .rst, .cycle_tick,
   .isum_mag, .residual_current, .event_store_sel, .count_clr, .rec_idx, .start_reg,
   .blocked_reg, .alarm_reg, .event_pulse_reg, .event_count_reg, .diff_mag_reg,
   .rec_valid_reg, .rec_data_reg);
